// *** hw/udcs_pkg.sv ***
// Constants for the USB device command and status front end.
// Assumes a 200 MHz core clock and a word-aligned register port.
package udcs_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFF_DEVICE_COMMAND_STATUS = 8'h00;
	localparam logic [7:0] OFF_CONTROLLER_INFO = 8'h04;
	localparam logic [7:0] OFF_ENDPOINT_LIST_START = 8'h08;
	localparam logic [7:0] OFF_DATA_BUFFER_START = 8'h0c;
	localparam logic [7:0] OFF_LINK_POWER_CONTROL = 8'h10;
	localparam logic [7:0] OFF_ENDPOINT_SKIP = 8'h14;
	localparam logic [7:0] OFF_ENDPOINT_BUFFER_IN_USE = 8'h18;
	localparam logic [7:0] OFF_ENDPOINT_BUFFER_CONFIG = 8'h1c;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h24;
	localparam logic [7:0] OFF_IRQ_STATUS_SET = 8'h28;
	localparam logic [7:0] OFF_IRQ_ROUTING = 8'h2c;
	localparam logic [7:0] OFF_ENDPOINT_TOGGLE = 8'h34;

	// Plain storage words: info, list start, buffer start, power, skip, in use, config, routing
	localparam int unsigned STORE_N = 8;

	// Command/status fields
	localparam int unsigned FA_LSB = 0;
	localparam int unsigned FA_W = 7;
	localparam int unsigned BIT_DEVICE_ENABLE_BIT = 7;
	localparam int unsigned BIT_SETUP = 8;
	localparam int unsigned BIT_CLK_KEEP = 9;
	localparam int unsigned BIT_LPM_SUP = 11;
	localparam int unsigned NAK_IRQ_LSB = 12;
	localparam int unsigned NAK_IRQ_W = 4;
	localparam int unsigned BIT_CONNECT = 16;
	localparam int unsigned BIT_SUSPENDED = 17;
	localparam int unsigned BIT_BUS_POWER = 28;
	localparam logic [31:0] CMD_RESET = 32'h0000_0800;
	// Bits that a write may store; setup, suspended and bus power are not stored
	localparam logic [31:0] CMD_WR_MASK = 32'h0001_faff;

	// Interrupt status bits
	localparam int unsigned IRQ_W = 5;
	localparam int unsigned IRQ_SETUP = 0;
	localparam int unsigned IRQ_FRAME = 1;
	localparam int unsigned IRQ_BUS_RESET = 2;
	localparam int unsigned IRQ_SUSPEND = 3;
	localparam int unsigned IRQ_BUS_POWER = 4;

	// Token kinds from the serial engine
	typedef enum logic [1:0] {UDCS_TOK_OUT, UDCS_TOK_IN, UDCS_TOK_SETUP, UDCS_TOK_SOF} udcs_tok_t;

	// Timing
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned IDLE_STOP_US = 2000;
	localparam int unsigned IDLE_STOP_CYC = IDLE_STOP_US * CLK_MHZ;
	localparam int unsigned HALF_FRAME_US = 500;
	localparam int unsigned HALF_FRAME_CYC = HALF_FRAME_US * CLK_MHZ;
endpackage : udcs_pkg

// *** hw/udcs_clock_keeper.sv ***
// Need-clock control during suspend.
// Assumes suspend and bus activity are synchronous levels from the serial engine.
`timescale 1ns/100ps
`default_nettype none
module udcs_clock_keeper #(
	parameter int unsigned IDLE_CYC = udcs_pkg::IDLE_STOP_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Controls
	input wire logic suspend_i,
	input wire logic activity_i,
	input wire logic keep_i,
	// Result
	output logic need_clock_o
);
	logic [31:0] idle_cnt;
	logic expired;

	// Restarts on any activity, so a brief glitch in suspend never stops the clock
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			idle_cnt <= 32'h0000_0000;
			expired <= 1'b0;
		end else if (!suspend_i || activity_i) begin
			idle_cnt <= 32'h0000_0000;
			expired <= 1'b0;
		end else if (idle_cnt >= IDLE_CYC - 32'h0000_0001) begin
			expired <= 1'b1;
		end else begin
			idle_cnt <= idle_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			need_clock_o <= 1'b1;
		end else begin
			need_clock_o <= keep_i || !(expired || (suspend_i && !activity_i
				&& idle_cnt >= IDLE_CYC - 32'h0000_0001));
		end
	end
endmodule : udcs_clock_keeper
`default_nettype wire

// *** hw/udcs_frame_marker.sv ***
// Frame output: high for half a frame after each start of frame.
// Limitation: frames shorter than the half period merge into one high level.
`timescale 1ns/100ps
`default_nettype none
module udcs_frame_marker #(
	parameter int unsigned HALF_CYC = udcs_pkg::HALF_FRAME_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Start of frame pulse
	input wire logic sof_i,
	// Marker
	output logic frame_o
);
	logic [31:0] cnt;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt <= 32'h0000_0000;
			frame_o <= 1'b0;
		end else if (sof_i) begin
			cnt <= HALF_CYC - 32'h0000_0001;
			frame_o <= 1'b1;
		end else if (cnt != 32'h0000_0000) begin
			cnt <= cnt - 32'h0000_0001;
		end else begin
			frame_o <= 1'b0;
		end
	end
endmodule : udcs_frame_marker
`default_nettype wire

// *** hw/udcs_top.sv ***
// Command/status front end of a full-speed USB device: register map,
// address filter, setup lock, need-clock, bus power, connect and frame outputs.
// Assumes a serial engine delivering synchronous token and event pulses.
`timescale 1ns/100ps
`default_nettype none
module udcs_top #(
	parameter int unsigned IDLE_CYC = udcs_pkg::IDLE_STOP_CYC,
	parameter int unsigned HALF_CYC = udcs_pkg::HALF_FRAME_CYC,
	parameter int unsigned EP_TOGGLE_W = 10
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Register port
	input wire logic [udcs_pkg::ADDR_W-1:0] addr_i,
	input wire logic [udcs_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [udcs_pkg::DATA_W-1:0] rdata_o,
	// Serial engine events
	input wire logic bus_reset_i,
	input wire logic token_valid_i,
	input wire udcs_pkg::udcs_tok_t token_kind_i,
	input wire logic [udcs_pkg::FA_W-1:0] token_addr_i,
	input wire logic token_ep0_i,
	input wire logic setup_ack_i,
	input wire logic suspend_i,
	input wire logic activity_i,
	input wire logic [EP_TOGGLE_W-1:0] ep_toggle_i,
	// Token answers
	output logic token_match_o,
	output logic token_nak_o,
	output logic token_pass_o,
	// Pins
	input wire logic bus_power_pin_i,
	input wire logic pin_configuration_i,
	output logic bus_power_o,
	output logic connect_o,
	output logic frame_pulse_output_o,
	output logic need_clock_output_o,
	// Interrupt
	output logic irq_o
);
	logic [31:0] cmd;
	logic [31:0] store [udcs_pkg::STORE_N];
	logic [udcs_pkg::IRQ_W-1:0] irq_status;
	logic [udcs_pkg::IRQ_W-1:0] irq_enable;
	logic [EP_TOGGLE_W-1:0] endpoint_toggle;
	logic [udcs_pkg::IRQ_W-1:0] events;
	logic [udcs_pkg::IRQ_W-1:0] next_irq_status;
	logic [udcs_pkg::IRQ_W-1:0] next_irq_enable;
	logic bus_power_sense;
	logic suspend_q;
	logic bus_power_q;
	logic addr_hit;
	logic setup_flag;
	logic need_clk;
	logic frame_mark;
	logic [31:0] next_rdata;

	function automatic logic hit(input logic [udcs_pkg::ADDR_W-1:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// Index into the plain storage words; returns STORE_N when not one of them
	function automatic int unsigned store_index(input logic [udcs_pkg::ADDR_W-1:0] a);
		store_index = udcs_pkg::STORE_N;
		if (hit(a, udcs_pkg::OFF_CONTROLLER_INFO)) store_index = 0;
		if (hit(a, udcs_pkg::OFF_ENDPOINT_LIST_START)) store_index = 1;
		if (hit(a, udcs_pkg::OFF_DATA_BUFFER_START)) store_index = 2;
		if (hit(a, udcs_pkg::OFF_LINK_POWER_CONTROL)) store_index = 3;
		if (hit(a, udcs_pkg::OFF_ENDPOINT_SKIP)) store_index = 4;
		if (hit(a, udcs_pkg::OFF_ENDPOINT_BUFFER_IN_USE)) store_index = 5;
		if (hit(a, udcs_pkg::OFF_ENDPOINT_BUFFER_CONFIG)) store_index = 6;
		if (hit(a, udcs_pkg::OFF_IRQ_ROUTING)) store_index = 7;
	endfunction : store_index

	assign bus_power_sense = pin_configuration_i ? bus_power_pin_i : 1'b1;
	assign setup_flag = cmd[udcs_pkg::BIT_SETUP];
	assign addr_hit = cmd[udcs_pkg::BIT_DEVICE_ENABLE_BIT]
		&& token_addr_i == cmd[udcs_pkg::FA_LSB +: udcs_pkg::FA_W];

	// Command and status word
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cmd <= udcs_pkg::CMD_RESET;
		end else begin
			if (wr_i && hit(addr_i, udcs_pkg::OFF_DEVICE_COMMAND_STATUS)) begin
				cmd <= (cmd & ~udcs_pkg::CMD_WR_MASK) | (wdata_i & udcs_pkg::CMD_WR_MASK);
				if (wdata_i[udcs_pkg::BIT_SETUP]) begin
					cmd[udcs_pkg::BIT_SETUP] <= 1'b0;
				end
			end
			// Setting outranks a simultaneous clear so a setup is never missed
			if (setup_ack_i) begin
				cmd[udcs_pkg::BIT_SETUP] <= 1'b1;
			end
			if (bus_reset_i) begin
				cmd[udcs_pkg::FA_LSB +: udcs_pkg::FA_W] <= '0;
			end
			cmd[udcs_pkg::BIT_SUSPENDED] <= suspend_i;
			cmd[udcs_pkg::BIT_BUS_POWER] <= bus_power_sense;
		end
	end

	// Plain read/write words
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < udcs_pkg::STORE_N; i++) begin
				store[i] <= 32'h0000_0000;
			end
		end else if (wr_i && store_index(addr_i) < udcs_pkg::STORE_N) begin
			store[store_index(addr_i)] <= wdata_i;
		end
	end

	// Toggle state mirrors the engine; software cannot write it
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			endpoint_toggle <= '0;
		end else begin
			endpoint_toggle <= ep_toggle_i;
		end
	end

	// Token answers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			token_match_o <= 1'b0;
			token_nak_o <= 1'b0;
			token_pass_o <= 1'b0;
		end else begin
			token_match_o <= token_valid_i && addr_hit;
			token_nak_o <= token_valid_i && addr_hit && setup_flag
				&& (token_kind_i == udcs_pkg::UDCS_TOK_IN
				|| token_kind_i == udcs_pkg::UDCS_TOK_OUT);
			token_pass_o <= token_valid_i && addr_hit && token_ep0_i && !setup_flag
				&& (token_kind_i == udcs_pkg::UDCS_TOK_IN
				|| token_kind_i == udcs_pkg::UDCS_TOK_OUT);
		end
	end

	// Edge history for event detection
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			suspend_q <= 1'b0;
			bus_power_q <= 1'b1;
		end else begin
			suspend_q <= suspend_i;
			bus_power_q <= bus_power_sense;
		end
	end

	always_comb begin
		events = '0;
		events[udcs_pkg::IRQ_SETUP] = setup_ack_i;
		events[udcs_pkg::IRQ_FRAME] = token_valid_i && token_kind_i == udcs_pkg::UDCS_TOK_SOF;
		events[udcs_pkg::IRQ_BUS_RESET] = bus_reset_i;
		events[udcs_pkg::IRQ_SUSPEND] = suspend_i != suspend_q;
		events[udcs_pkg::IRQ_BUS_POWER] = bus_power_sense != bus_power_q;
	end

	// Read clears status; new events and set writes win over that clear
	always_comb begin
		next_irq_status = irq_status;
		if (rd_i && hit(addr_i, udcs_pkg::OFF_IRQ_STATUS)) begin
			next_irq_status = '0;
		end
		if (wr_i && hit(addr_i, udcs_pkg::OFF_IRQ_STATUS_SET)) begin
			next_irq_status = next_irq_status | wdata_i[udcs_pkg::IRQ_W-1:0];
		end
		next_irq_status = next_irq_status | events;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_status <= '0;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	always_comb begin
		next_irq_enable = irq_enable;
		if (wr_i && hit(addr_i, udcs_pkg::OFF_IRQ_ENABLE)) begin
			next_irq_enable = wdata_i[udcs_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_enable <= '0;
		end else begin
			irq_enable <= next_irq_enable;
		end
	end

	// Next status and enable, so masking never leaves a stale cycle on the line
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(next_irq_status & next_irq_enable);
		end
	end

	// Read mux; unmapped offsets and the hole at 0x30 answer zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit(addr_i, udcs_pkg::OFF_DEVICE_COMMAND_STATUS)) begin
			next_rdata = cmd;
		end else if (store_index(addr_i) < udcs_pkg::STORE_N) begin
			next_rdata = store[store_index(addr_i)];
		end else if (hit(addr_i, udcs_pkg::OFF_IRQ_STATUS)
			|| hit(addr_i, udcs_pkg::OFF_IRQ_STATUS_SET)) begin
			next_rdata[udcs_pkg::IRQ_W-1:0] = irq_status;
		end else if (hit(addr_i, udcs_pkg::OFF_IRQ_ENABLE)) begin
			next_rdata[udcs_pkg::IRQ_W-1:0] = irq_enable;
		end else if (hit(addr_i, udcs_pkg::OFF_ENDPOINT_TOGGLE)) begin
			next_rdata[EP_TOGGLE_W-1:0] = endpoint_toggle;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	udcs_clock_keeper #(
		.IDLE_CYC(IDLE_CYC)
	) u_keeper (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.suspend_i(suspend_i),
		.activity_i(activity_i),
		.keep_i(cmd[udcs_pkg::BIT_CLK_KEEP]),
		.need_clock_o(need_clk)
	);

	udcs_frame_marker #(
		.HALF_CYC(HALF_CYC)
	) u_frame (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.sof_i(events[udcs_pkg::IRQ_FRAME]),
		.frame_o(frame_mark)
	);

	// Pin outputs
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bus_power_o <= 1'b1;
			connect_o <= 1'b0;
			frame_pulse_output_o <= 1'b0;
			need_clock_output_o <= 1'b1;
		end else begin
			bus_power_o <= bus_power_sense;
			connect_o <= cmd[udcs_pkg::BIT_CONNECT];
			frame_pulse_output_o <= frame_mark;
			need_clock_output_o <= need_clk;
		end
	end
endmodule : udcs_top
`default_nettype wire

// *** verif/udcs_top_checker.sv ***
// Port assertions for the command/status front end.
// Assumes one clock domain; shadows the address, enable and keep bits.
`timescale 1ns/100ps
`default_nettype none
module udcs_top_checker #(
	parameter int unsigned IDLE_CYC = 20
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	// Engine
	input wire logic bus_reset_i,
	input wire logic token_valid_i,
	input wire udcs_pkg::udcs_tok_t token_kind_i,
	input wire logic [6:0] token_addr_i,
	input wire logic setup_ack_i,
	input wire logic suspend_i,
	input wire logic activity_i,
	input wire logic token_match_o,
	input wire logic token_nak_o,
	input wire logic token_pass_o,
	// Pins
	input wire logic pin_configuration_i,
	input wire logic bus_power_o,
	input wire logic need_clock_output_o
);
	logic [6:0] fa;
	logic en;
	logic keep;
	int unsigned idle_cnt;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fa <= '0;
			en <= 1'b0;
			keep <= 1'b0;
		end else begin
			if (wr_i && addr_i == 8'h00) begin
				fa <= wdata_i[6:0];
				en <= wdata_i[7];
				keep <= wdata_i[9];
			end
			// Bus reset outranks a same-cycle address write
			if (bus_reset_i) begin
				fa <= '0;
			end
		end
	end
	// Saturates so a long suspend cannot wrap back under the limit
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			idle_cnt <= 0;
		end else if (suspend_i && !activity_i) begin
			idle_cnt <= (idle_cnt > IDLE_CYC + 8) ? idle_cnt : idle_cnt + 1;
		end else begin
			idle_cnt <= 0;
		end
	end
	AST_NAK_MATCH: assert property (token_nak_o |-> token_match_o)
		else $error("nak without match");
	AST_MATCH_ADDR: assert property (token_match_o |-> $past(token_valid_i) && $past(en)
		&& $past(token_addr_i) == $past(fa)) else $error("match on wrong address");
	AST_BUS_POWER: assert property (!pin_configuration_i |=> bus_power_o)
		else $error("bus power low while unselected");
	AST_HOLE_ZERO: assert property (rd_i && addr_i == 8'h30 |=> rdata_o == 32'h0)
		else $error("hole reads nonzero");
	AST_SETUP_NAK: assert property (setup_ack_i ##1 !wr_i ##1
		(token_valid_i && !token_kind_i[1]) |=> !token_match_o || token_nak_o)
		else $error("token not naked after setup");
	AST_SETUP_CLEAR: assert property (wr_i && addr_i == 8'h00 && wdata_i[8] && !setup_ack_i
		##1 !setup_ack_i ##1 token_valid_i |=> !token_nak_o) else $error("flag not cleared");
	AST_KEEP_CLOCK: assert property (keep && $past(keep) && $past(keep, 2)
		|-> need_clock_output_o) else $error("need clock low with keep");
	AST_IDLE_STOP: assert property (idle_cnt > IDLE_CYC + 2 && !keep && !$past(keep)
		&& !$past(keep, 2) |-> !need_clock_output_o) else $error("need clock high after idle");
	COV_NAK: cover property (token_nak_o);
	COV_PASS: cover property (token_pass_o);
	COV_STOP: cover property (!need_clock_output_o);
endmodule : udcs_top_checker
bind udcs_top udcs_top_checker #(.IDLE_CYC(IDLE_CYC)) u_chk (.clk_i(clk_i),
	.arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .bus_reset_i(bus_reset_i), .token_valid_i(token_valid_i),
	.token_kind_i(token_kind_i), .token_addr_i(token_addr_i), .setup_ack_i(setup_ack_i),
	.suspend_i(suspend_i), .activity_i(activity_i), .token_match_o(token_match_o),
	.token_nak_o(token_nak_o), .token_pass_o(token_pass_o),
	.pin_configuration_i(pin_configuration_i), .bus_power_o(bus_power_o),
	.need_clock_output_o(need_clock_output_o));
`default_nettype wire

// *** verif/udcs_host_model.sv ***
// Host and serial engine stand-in: token, setup ack and bus reset pulses.
// Assumes callers run on clk_i; lines move just after rising edges.
`timescale 1ns/100ps
`default_nettype none
module udcs_host_model (
	// Clock
	input wire logic clk_i,
	// Engine lines
	output logic tok_v_o,
	output udcs_pkg::udcs_tok_t kind_o,
	output logic [6:0] addr_o,
	output logic ep0_o,
	output logic ack_o,
	output logic brst_o
);
	initial begin
		tok_v_o = 1'b0;
		kind_o = udcs_pkg::UDCS_TOK_SOF;
		addr_o = '0;
		ep0_o = 1'b0;
		ack_o = 1'b0;
		brst_o = 1'b0;
	end
	// Released address and endpoint lines flip and valid drops, so stale values never look valid; kind holds
	task automatic tok(input udcs_pkg::udcs_tok_t k, input logic [6:0] a, input logic e);
		@(posedge clk_i);
		tok_v_o <= 1'b1;
		kind_o <= k;
		addr_o <= a;
		ep0_o <= e;
		@(posedge clk_i);
		tok_v_o <= 1'b0;
		addr_o <= ~a;
		ep0_o <= ~e;
	endtask : tok
	task automatic setup(input logic [6:0] a);
		tok(udcs_pkg::UDCS_TOK_SETUP, a, 1'b1);
		ack_o <= 1'b1;
		@(posedge clk_i);
		ack_o <= 1'b0;
	endtask : setup
	task automatic breset;
		@(posedge clk_i);
		brst_o <= 1'b1;
		@(posedge clk_i);
		brst_o <= 1'b0;
	endtask : breset
endmodule : udcs_host_model
`default_nettype wire

// *** verif/usb_device_command_status_tb.sv ***
// Self-checking bench for the command/status front end.
// Assumes short idle and frame counts so the run stays brief.
`timescale 1ns/100ps
`default_nettype none
module usb_device_command_status_tb;
	localparam int unsigned IDLE = 20;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr, rd, susp, act, pin, pcfg, tv, e0, ack, brst;
	logic [9:0] tog;
	logic [6:0] ta;
	udcs_pkg::udcs_tok_t kind;
	logic [31:0] rdata;
	logic match, nak, pass, bpow, conn, frame, nclk, irq;
	int fail_count = 0;
	int num_checks = 0;
	logic [7:0] offs [8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h2c};
	udcs_top #(.IDLE_CYC(IDLE), .HALF_CYC(10)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.bus_reset_i(brst), .token_valid_i(tv), .token_kind_i(kind), .token_addr_i(ta),
		.token_ep0_i(e0), .setup_ack_i(ack), .suspend_i(susp), .activity_i(act),
		.ep_toggle_i(tog), .token_match_o(match), .token_nak_o(nak), .token_pass_o(pass),
		.bus_power_pin_i(pin), .pin_configuration_i(pcfg), .bus_power_o(bpow),
		.connect_o(conn), .frame_pulse_output_o(frame), .need_clock_output_o(nclk),
		.irq_o(irq));
	udcs_host_model host (.clk_i(clk_i), .tok_v_o(tv), .kind_o(kind), .addr_o(ta),
		.ep0_o(e0), .ack_o(ack), .brst_o(brst));
	initial forever #2.5 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask : wr_reg
	// Data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd_reg
	task automatic tk(input udcs_pkg::udcs_tok_t k, input logic [6:0] a, input logic [2:0] e);
		host.tok(k, a, 1'b1);
		#1;
		chk({29'h0, match, nak, pass}, {29'h0, e});
	endtask : tk
	task automatic end_sim;
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	initial begin
		#20us;
		fail_count++;
		end_sim;
	end
	initial begin
		{addr, wdata, wr, rd, susp, act, tog, pin, pcfg} = '0;
		repeat (20) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd_reg(8'h00, 32'h1000_0800);
		wr_reg(8'h34, 32'hffff_ffff);
		rd_reg(8'h34, 32'h0);
		@(posedge clk_i);
		tog <= 10'h2a5;
		wr_reg(8'h34, 32'h0000_0000);
		rd_reg(8'h34, 32'h0000_02a5);
		wr_reg(8'h30, 32'hffff_ffff);
		rd_reg(8'h30, 32'h0);
		foreach (offs[i]) begin
			rd_reg(offs[i], 32'h0);
			wr_reg(offs[i], 32'h5a00_0000 | i);
			rd_reg(offs[i], 32'h5a00_0000 | i);
		end
		wr_reg(8'h00, 32'h0000_0085);
		tk(udcs_pkg::UDCS_TOK_IN, 7'h05, 3'b101);
		tk(udcs_pkg::UDCS_TOK_OUT, 7'h06, 3'b000);
		host.setup(7'h05);
		tk(udcs_pkg::UDCS_TOK_IN, 7'h05, 3'b110);
		rd_reg(8'h00, 32'h1000_0185);
		tk(udcs_pkg::UDCS_TOK_OUT, 7'h05, 3'b110);
		wr_reg(8'h00, 32'h0000_0185);
		tk(udcs_pkg::UDCS_TOK_OUT, 7'h05, 3'b101);
		host.breset;
		rd_reg(8'h00, 32'h1000_0080);
		tk(udcs_pkg::UDCS_TOK_IN, 7'h05, 3'b000);
		tk(udcs_pkg::UDCS_TOK_IN, 7'h00, 3'b101);
		wr_reg(8'h00, 32'h0000_0005);
		tk(udcs_pkg::UDCS_TOK_IN, 7'h05, 3'b000);
		rd_reg(8'h20, 32'h0000_0005);
		host.tok(udcs_pkg::UDCS_TOK_SOF, 7'h00, 1'b0);
		rd_reg(8'h20, 32'h0000_0002);
		chk(irq, 0);
		wr_reg(8'h24, 32'h0000_0002);
		host.tok(udcs_pkg::UDCS_TOK_SOF, 7'h00, 1'b0);
		@(posedge clk_i);
		#1;
		chk(irq, 1);
		chk(frame, 1);
		rd_reg(8'h20, 32'h0000_0002);
		chk(irq, 0);
		wr_reg(8'h28, 32'h0000_0006);
		#1;
		chk(irq, 1);
		wr_reg(8'h24, 32'h0);
		#1;
		chk(irq, 0);
		rd_reg(8'h20, 32'h0000_0006);
		@(posedge clk_i);
		pcfg <= 1'b1;
		pin <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		chk(bpow, 0);
		chk(frame, 0);
		@(posedge clk_i);
		pcfg <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		chk(bpow, 1);
		@(posedge clk_i);
		susp <= 1'b1;
		repeat (IDLE - 2) @(posedge clk_i);
		#1;
		chk(nclk, 1);
		repeat (6) @(posedge clk_i);
		#1;
		chk(nclk, 0);
		@(posedge clk_i);
		act <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		chk(nclk, 1);
		@(posedge clk_i);
		{susp, act} <= 2'b00;
		wr_reg(8'h00, 32'h0001_0200);
		@(posedge clk_i);
		susp <= 1'b1;
		repeat (IDLE + 8) @(posedge clk_i);
		#1;
		chk(nclk, 1);
		chk(conn, 1);
		end_sim;
	end
endmodule : usb_device_command_status_tb
`default_nettype wire
